// ==== rtl/iqr_head_remove.sv ====
// Interlocked head-removal engine for self-relative memory queues
`timescale 1ns/1ns
`default_nettype none
`include "iqr_regs.svh"
module iqr_head_remove
   import iqr_pkg::*;
#(
   parameter logic [`IQR_CNT_W-1:0] RETRY_N = `IQR_RETRY_DEFAULT
)(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire iqr_start_t  start,
   output logic             startReady,
   output iqr_mreq_t        memReq,
   input  wire iqr_mrsp_t   memRsp,
   output iqr_result_t      result
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      iqr_state_t              state;
      logic [63:0]             hdr;
      logic                    quad;
      logic [63:0]             tmp0;
      logic [63:0]             fwd;
      logic [63:0]             entry;
      logic [63:0]             succ;
      logic [`IQR_CNT_W-1:0]   cnt;
      iqr_exc_t                pendExc;
      iqr_mreq_t               req;
      iqr_result_t             res;
   } iqr_st_t;

   iqr_st_t r_reg;
   iqr_st_t r_next;

   // Sign extension of the low word
   function automatic logic [63:0] sx(input logic [63:0] v);
      sx = {{32{v[`IQR_SIGN_EXTEND_MSB]}}, v[`IQR_SIGN_EXTEND_MSB:0]};
   endfunction : sx

   // Request builder
   function automatic iqr_mreq_t mk(input iqr_kind_t k, input logic [63:0] a,
                                    input logic [63:0] d, input logic w);
      mk.valid = 1'b1;
      mk.kind  = k;
      mk.addr  = a;
      mk.wdata = d;
      mk.wide  = w;
   endfunction : mk

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      logic [63:0] f;
      logic [63:0] e;
      logic [63:0] s;
      f = `IQR_ZERO;
      e = `IQR_ZERO;
      s = `IQR_ZERO;
      r_next = r_reg;
      r_next.res.done = 1'b0;
      if (memRsp.ack)
      begin
         r_next.req.valid = 1'b0;
      end
      case (r_reg.state)
         IQR_IDLE:
         begin
            if (start.valid)
            begin
               r_next.hdr  = start.hdrAddr;
               r_next.quad = start.quad;
               r_next.cnt  = RETRY_N;
               if (start.quad && ((start.hdrAddr & `IQR_QALIGN_MASK) != `IQR_ZERO))
               begin
                  r_next.res = '{1'b1, `IQR_ZERO, `IQR_ZERO, IQR_X_ILLOP}; // [RULE_12]
               end
               else
               begin
                  // Variant ignores alignment for long queues [RULE_11]
                  r_next.req   = mk(IQR_K_RESLOAD, start.hdrAddr, `IQR_ZERO, start.quad);
                  r_next.state = IQR_LL; // [RULE_02]
               end
            end
         end
         IQR_LL:
         begin
            if (memRsp.ack)
            begin
               r_next.tmp0 = memRsp.rdata;
               if (memRsp.fault != IQR_X_NONE)
               begin
                  r_next.res   = '{1'b1, `IQR_ZERO, `IQR_ZERO, memRsp.fault}; // [RULE_15]
                  r_next.state = IQR_IDLE;
               end
               else if (memRsp.rdata[`IQR_LOCK_BIT])
               begin
                  r_next.res   = '{1'b1, `IQR_ST_LOCKED, `IQR_ZERO, IQR_X_NONE}; // [RULE_02]
                  r_next.state = IQR_IDLE;
               end
               else
               begin
                  r_next.req   = mk(IQR_K_CONDSTORE, r_reg.hdr,
                                    memRsp.rdata | `IQR_ONE, r_reg.quad); // [RULE_03]
                  r_next.state = IQR_SC;
               end
            end
         end
         IQR_SC:
         begin
            if (memRsp.ack)
            begin
               if (memRsp.ok)
               begin
                  r_next.req   = mk(IQR_K_FENCE, r_reg.hdr, `IQR_ZERO, r_reg.quad); // [RULE_05]
                  r_next.state = IQR_FENCE1;
               end
               else if (r_reg.cnt <= `IQR_CNT_W'(1))
               begin
                  r_next.res   = '{1'b1, `IQR_ST_LOCKED, `IQR_ZERO, IQR_X_NONE}; // [RULE_04]
                  r_next.state = IQR_IDLE;
               end
               else
               begin
                  r_next.cnt   = r_reg.cnt - `IQR_CNT_W'(1);
                  r_next.req   = mk(IQR_K_RESLOAD, r_reg.hdr, `IQR_ZERO, r_reg.quad); // [RULE_03]
                  r_next.state = IQR_LL;
               end
            end
         end
         IQR_FENCE1:
         begin
            if (memRsp.ack)
            begin
               f = r_reg.quad ? r_reg.tmp0 : sx(r_reg.tmp0); // [RULE_09]
               e = r_reg.quad ? r_reg.hdr + f : sx(r_reg.hdr + f); // [RULE_05]
               r_next.fwd   = f;
               r_next.entry = e;
               if (r_reg.quad && ((f & `IQR_QALIGN_MASK) != `IQR_ZERO))
               begin
                  r_next.pendExc = IQR_X_ILLOP; // [RULE_13]
                  r_next.req     = mk(IQR_K_WRITE, r_reg.hdr, r_reg.tmp0, r_reg.quad);
                  r_next.state   = IQR_RESTORE;
               end
               else if (f == `IQR_ZERO)
               begin
                  // Empty queue: the successor is the header [RULE_06]
                  r_next.succ = r_reg.hdr;
                  if (r_reg.quad)
                  begin
                     r_next.req   = mk(IQR_K_PROBEW, r_reg.hdr + `IQR_BLINK_QUAD,
                                       `IQR_ZERO, 1'b1); // [RULE_14]
                     r_next.state = IQR_PROBE;
                  end
                  else
                  begin
                     r_next.req   = mk(IQR_K_WRITE, r_reg.hdr + `IQR_BLINK_LONG,
                                       `IQR_ZERO, 1'b0); // [RULE_07]
                     r_next.state = IQR_WRBACK;
                  end
               end
               else
               begin
                  r_next.req   = mk(IQR_K_READ, e, `IQR_ZERO, r_reg.quad); // [RULE_06]
                  r_next.state = IQR_RDENT;
               end
            end
         end
         IQR_RDENT:
         begin
            if (memRsp.ack)
            begin
               s = r_reg.quad ? r_reg.entry + memRsp.rdata
                              : sx(r_reg.entry + sx(memRsp.rdata)); // [RULE_09]
               r_next.succ = s;
               if (r_reg.quad && memRsp.fault != IQR_X_NONE)
               begin
                  r_next.pendExc = memRsp.fault; // [RULE_14]
                  r_next.req     = mk(IQR_K_WRITE, r_reg.hdr, r_reg.tmp0, 1'b1);
                  r_next.state   = IQR_RESTORE;
               end
               else if (r_reg.quad && ((s & `IQR_QALIGN_MASK) != `IQR_ZERO))
               begin
                  r_next.pendExc = IQR_X_ILLOP; // [RULE_13]
                  r_next.req     = mk(IQR_K_WRITE, r_reg.hdr, r_reg.tmp0, 1'b1);
                  r_next.state   = IQR_RESTORE;
               end
               else if (r_reg.quad)
               begin
                  r_next.req   = mk(IQR_K_PROBEW, s + `IQR_BLINK_QUAD, `IQR_ZERO, 1'b1);
                  r_next.state = IQR_PROBE; // [RULE_14]
               end
               else
               begin
                  r_next.req   = mk(IQR_K_WRITE, s + `IQR_BLINK_LONG,
                                    sx(r_reg.hdr - s), 1'b0); // [RULE_07]
                  r_next.state = IQR_WRBACK;
               end
            end
         end
         IQR_PROBE:
         begin
            if (memRsp.ack)
            begin
               if (memRsp.fault != IQR_X_NONE)
               begin
                  r_next.pendExc = memRsp.fault; // [RULE_14]
                  r_next.req     = mk(IQR_K_WRITE, r_reg.hdr, r_reg.tmp0, 1'b1);
                  r_next.state   = IQR_RESTORE;
               end
               else
               begin
                  r_next.req   = mk(IQR_K_WRITE, r_reg.succ + `IQR_BLINK_QUAD,
                                    r_reg.hdr - r_reg.succ, 1'b1); // [RULE_07]
                  r_next.state = IQR_WRBACK;
               end
            end
         end
         IQR_WRBACK:
         begin
            if (memRsp.ack)
            begin
               r_next.req   = mk(IQR_K_FENCE, r_reg.hdr, `IQR_ZERO, r_reg.quad); // [RULE_08]
               r_next.state = IQR_FENCE2;
            end
         end
         IQR_FENCE2:
         begin
            if (memRsp.ack)
            begin
               r_next.req   = mk(IQR_K_WRITE, r_reg.hdr, r_reg.quad ?
                                 r_reg.succ - r_reg.hdr : sx(r_reg.succ - r_reg.hdr),
                                 r_reg.quad); // [RULE_08]
               r_next.state = IQR_WRFWD;
            end
         end
         IQR_WRFWD:
         begin
            if (memRsp.ack)
            begin
               r_next.res.done    = 1'b1; // [RULE_17]
               r_next.res.exc     = IQR_X_NONE;
               r_next.res.removed = r_reg.entry; // [RULE_05]
               if (r_reg.fwd == `IQR_ZERO)
               begin
                  r_next.res.status = `IQR_ST_EMPTY; // [RULE_01]
               end
               else if (r_reg.succ == r_reg.hdr)
               begin
                  r_next.res.status = `IQR_ST_NOW_EMPTY; // [RULE_01]
               end
               else
               begin
                  r_next.res.status = `IQR_ST_MORE; // [RULE_01]
               end
               r_next.state = IQR_IDLE;
            end
         end
         IQR_RESTORE:
         begin
            if (memRsp.ack)
            begin
               r_next.res   = '{1'b1, `IQR_ZERO, `IQR_ZERO, r_reg.pendExc}; // [RULE_15]
               r_next.state = IQR_IDLE;
            end
         end
         default:
         begin
            r_next.state = IQR_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Registers and outputs
   // ----------------------------------------
   // One removal at a time, never preempted [RULE_16]
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r_reg       <= '0; // First state of the enum is idle
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign startReady = (r_reg.state == IQR_IDLE);
   assign memReq     = r_reg.req;
   assign result     = r_reg.res;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence sc_fail_last;
      r_reg.state == IQR_SC && memRsp.ack && !memRsp.ok && r_reg.cnt == `IQR_CNT_W'(1);
   endsequence
   sequence fence2_done;
      r_reg.state == IQR_FENCE2 && memRsp.ack;
   endsequence
   hdr_align_a: assert property (startReady && start.valid && start.quad && // [RULE_12]
      start.hdrAddr[3:0] != 4'h0 |=> result.done && result.exc == IQR_X_ILLOP)
      else $error("misaligned quad header not refused");
   lock_busy_a: assert property (r_reg.state == IQR_LL && memRsp.ack && // [RULE_02]
      memRsp.fault == IQR_X_NONE && memRsp.rdata[`IQR_LOCK_BIT] |=> result.done &&
      result.status == `IQR_ST_LOCKED) else $error("set lock bit not reported");
   cs_data_a: assert property (memReq.valid && memReq.kind == IQR_K_CONDSTORE |-> // [RULE_03]
      memReq.wdata == (r_reg.tmp0 | `IQR_ONE))
      else $error("conditional store data wrong");
   retry_out_a: assert property (sc_fail_last |=> result.done && // [RULE_04]
      result.status == `IQR_ST_LOCKED ##1 startReady)
      else $error("retry exhaustion not reported");
   fwd_order_a: assert property (fence2_done |=> memReq.valid && // [RULE_08]
      memReq.kind == IQR_K_WRITE && memReq.addr == r_reg.hdr)
      else $error("forward write not after fence");
   back_link_a: assert property (r_reg.state == IQR_WRBACK && memReq.valid |-> // [RULE_07]
      memReq.addr == r_reg.succ + (r_reg.quad ? `IQR_BLINK_QUAD : `IQR_BLINK_LONG))
      else $error("backward link offset wrong");
   restore_a: assert property (r_reg.state == IQR_RESTORE && memReq.valid |-> // [RULE_13]
      memReq.addr == r_reg.hdr && memReq.wdata == r_reg.tmp0)
      else $error("restore writes wrong value");
   empty_res_a: assert property (result.done && result.exc == IQR_X_NONE && // [RULE_06]
      result.status == `IQR_ST_EMPTY |-> result.removed == r_reg.hdr)
      else $error("empty queue result address wrong");
   long_sign_extend_a: assert property (result.done && !r_reg.quad && // [RULE_09]
      result.exc == IQR_X_NONE && result.status != `IQR_ST_LOCKED |->
      result.removed[63:32] == {32{result.removed[31]}})
      else $error("long address not sign extended");
endmodule : iqr_head_remove
`default_nettype wire

// ==== rtl/iqr_regs.svh ====
// Constants of the interlocked head-removal engine
// Functional notes
// [RULE_01] Status 0 empty with lock obtained, 1 removed and more remain, 2 removed now empty.
// [RULE_02] Header read by reserved load; bit 0 already set returns -1 untouched.
// [RULE_03] Conditional store of header OR 1, retried until success or count exhausted.
// [RULE_04] Retry count exhausted without exception returns -1, queue unchanged.
// [RULE_05] Fence after lock; removed address is header plus forward link, returned.
// [RULE_06] Successor is entry plus its forward link; empty queue uses header itself.
// [RULE_07] Successor backward link gets header minus successor, offset 4 long, 8 quad.
// [RULE_08] Fence after backward write, then forward link write releases the lock.
// [RULE_09] Long variant sign-extends low 32 bits of forward link and addresses.
// [RULE_10] Software keeps long queues quadword aligned, resident and writable.
// [RULE_11] Long variant makes no alignment or memory checks before modifying.
// [RULE_12] Quad variant faults illegal operand on header address low four bits nonzero.
// [RULE_13] Quad misaligned forward link or successor restores header, then illegal operand.
// [RULE_14] Quad confirms entry read and successor write first; else restore, then fault.
// [RULE_15] Quad reports access, read, write, illegal operand and translation exceptions.
// [RULE_16] Removal runs uninterrupted; interlock excludes other removals and insertions.
// [RULE_17] Start request with header and variant; completion with status, address or exception.
`ifndef IQR_REGS_SVH
`define IQR_REGS_SVH
`define IQR_RETRY_DEFAULT 16'h0010
`define IQR_CNT_W         16
`define IQR_LOCK_BIT      0
`define IQR_SIGN_EXTEND_MSB      31
`define IQR_QALIGN_MASK   64'h0000_0000_0000_000F
`define IQR_BLINK_LONG    64'h0000_0000_0000_0004
`define IQR_BLINK_QUAD    64'h0000_0000_0000_0008
`define IQR_ST_LOCKED     64'hFFFF_FFFF_FFFF_FFFF
`define IQR_ST_EMPTY      64'h0000_0000_0000_0000
`define IQR_ST_MORE       64'h0000_0000_0000_0001
`define IQR_ST_NOW_EMPTY  64'h0000_0000_0000_0002
`define IQR_ONE           64'h0000_0000_0000_0001
`define IQR_ZERO          64'h0000_0000_0000_0000
`endif

// ==== rtl/iqr_pkg.sv ====
// Types of the interlocked head-removal engine
package iqr_pkg;
   typedef enum logic [2:0] {IQR_K_RESLOAD, IQR_K_CONDSTORE, IQR_K_READ, IQR_K_WRITE,
                             IQR_K_FENCE, IQR_K_PROBEW} iqr_kind_t;
   typedef enum logic [2:0] {IQR_X_NONE, IQR_X_ILLOP, IQR_X_ACCVIO, IQR_X_FOR,
                             IQR_X_FOW, IQR_X_TNV} iqr_exc_t;
   typedef enum {IQR_IDLE, IQR_LL, IQR_SC, IQR_FENCE1, IQR_RDENT, IQR_PROBE,
                 IQR_WRBACK, IQR_FENCE2, IQR_WRFWD, IQR_RESTORE} iqr_state_t;
   typedef struct packed {
      logic        valid;
      logic [63:0] hdrAddr;
      logic        quad;
   } iqr_start_t;
   typedef struct packed {
      logic        valid;
      iqr_kind_t   kind;
      logic [63:0] addr;
      logic [63:0] wdata;
      logic        wide;
   } iqr_mreq_t;
   typedef struct packed {
      logic        ack;
      logic [63:0] rdata;
      logic        ok;
      iqr_exc_t    fault;
   } iqr_mrsp_t;
   typedef struct packed {
      logic        done;
      logic [63:0] status;
      logic [63:0] removed;
      iqr_exc_t    exc;
   } iqr_result_t;
endpackage : iqr_pkg

// ==== bench/iqr_mem_model.sv ====
// Memory-side partner model with reserved load, conditional store and fault injection
`timescale 1ns/1ns
`default_nettype none
module iqr_mem_model
   import iqr_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_b,
   input  wire iqr_mreq_t memReq,
   output var  iqr_mrsp_t memRsp
);
   // ----------------------------------------------------------------
   // Storage, trace and knobs set by the bench
   // ----------------------------------------------------------------
   logic [31:0] mem [logic [61:0]];
   iqr_kind_t   kinds [$];
   logic [63:0] addrs [$];
   int          lag       = 0;
   int          scFails   = 0;
   int          waitCnt   = 0;
   logic [63:0] faultAddr = 64'hFFFF_FFFF_FFFF_FFF0;
   iqr_exc_t    faultCode = IQR_X_NONE;

   function automatic logic [31:0] rd(input logic [63:0] a);
      return mem.exists(a[63:2]) ? mem[a[63:2]] : 32'h0000_0000;
   endfunction : rd

   function automatic logic [63:0] peek(input logic [63:0] a);
      return {rd(a + 64'h4), rd(a)};
   endfunction : peek

   task automatic wr(input logic [63:0] a, input logic [63:0] d, input logic w);
      mem[a[63:2]] = d[31:0];
      if (w)
         mem[a[63:2] + 62'h1] = d[63:32];
   endtask : wr

   // ----------------------------------------------------------------
   // One outstanding request, acked after lag cycles
   // ----------------------------------------------------------------
   // Idle read data toggles so a stale value is never mistaken for an answer
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         memRsp  <= '0;
         waitCnt <= 0;
      end
      else
      begin
         memRsp.ack   <= 1'b0;
         memRsp.rdata <= ~memRsp.rdata;
         if (memReq.valid && !memRsp.ack && waitCnt < lag)
            waitCnt <= waitCnt + 1;
         else if (memReq.valid && !memRsp.ack)
         begin
            waitCnt      <= 0;
            memRsp.ack   <= 1'b1;
            memRsp.ok    <= 1'b0;
            memRsp.fault <= (memReq.addr == faultAddr) ? faultCode : IQR_X_NONE;
            kinds.push_back(memReq.kind);
            addrs.push_back(memReq.addr);
            if (memReq.kind == IQR_K_RESLOAD || memReq.kind == IQR_K_READ)
               memRsp.rdata <= memReq.wide ? peek(memReq.addr) :
                               {~rd(memReq.addr), rd(memReq.addr)};
            else if (memReq.kind == IQR_K_CONDSTORE && scFails > 0)
               scFails--;   // Reservation lost, store refused
            else if (memReq.addr != faultAddr && (memReq.kind == IQR_K_CONDSTORE ||
                     memReq.kind == IQR_K_WRITE))
            begin
               memRsp.ok <= 1'b1;
               wr(memReq.addr, memReq.wdata, memReq.wide);
            end
         end
      end
   end
endmodule : iqr_mem_model
`default_nettype wire

// ==== bench/interlocked_queue_head_remove_test.sv ====
// Self-checking bench for the interlocked head-removal engine
`timescale 1ns/1ns
`default_nettype none
`include "iqr_regs.svh"
module interlocked_queue_head_remove_test
   import iqr_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_b;
   iqr_start_t  start;
   logic        startReady;
   iqr_mreq_t   memReq;
   iqr_mrsp_t   memRsp;
   iqr_result_t result;
   int          failures = 0;
   int          checksDone = 0;

   always #4 clk = ~clk;

   iqr_head_remove #(.RETRY_N(16'h0002)) i_iqr_head_remove (.clk(clk), .rst_b(rst_b),
      .start(start), .startReady(startReady), .memReq(memReq), .memRsp(memRsp),
      .result(result));
   iqr_mem_model i_iqr_mem_model (.clk(clk), .rst_b(rst_b), .memReq(memReq),
      .memRsp(memRsp));

   // ----------------------------------------------------------------
   // Compare and drive helpers
   // ----------------------------------------------------------------
   task automatic chkWord(input string what, input logic [63:0] exp, input logic [63:0] got);
      checksDone++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chkWord

   task automatic chkExc(input string what, input iqr_exc_t exp, input iqr_exc_t got);
      checksDone++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chkExc

   task automatic chkKinds(input iqr_kind_t e[$]);
      chkWord("transfer count", 64'(e.size()), 64'(i_iqr_mem_model.kinds.size()));
      foreach (e[i])
         if (i < i_iqr_mem_model.kinds.size())
            chkWord("transfer kind", 64'(e[i]), 64'(i_iqr_mem_model.kinds[i]));
   endtask : chkKinds

   task automatic chkResult(input logic [63:0] st, input logic [63:0] rm, input iqr_exc_t x);
      chkWord("status", st, result.status);
      chkWord("removed", rm, result.removed);
      chkExc("exception", x, result.exc);
   endtask : chkResult

   // One removal; meddle holds a second start up for the first four cycles the engine is busy
   task automatic run(input logic [63:0] hdr, input logic quad, input logic meddle);
      int n;
      n = 0;
      i_iqr_mem_model.kinds.delete();
      i_iqr_mem_model.addrs.delete();
      @(posedge clk);
      start <= '{1'b1, hdr, quad};
      @(posedge clk);
      start <= '{meddle, hdr ^ 64'h0000_0000_0000_0100, ~quad};
      @(negedge clk);
      while (result.done !== 1'b1 && n < 500)
      begin
         if (meddle && n < 4)
            chkWord("startReady busy", 64'h0, {63'h0, startReady});
         @(posedge clk);
         if (n == 3)
            start.valid <= 1'b0;
         @(negedge clk);
         n++;
      end
      chkWord("done", 64'h1, {63'h0, result.done});
   endtask : run

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic longLast;
      i_iqr_mem_model.lag = 2;
      i_iqr_mem_model.wr(64'h1000, 64'h0000_0040_0000_0040, 1'b1);
      i_iqr_mem_model.wr(64'h1040, 64'hFFFF_FFC0_FFFF_FFC0, 1'b1);
      run(64'h1000, 1'b0, 1'b1);
      chkResult(`IQR_ST_NOW_EMPTY, 64'h1040, IQR_X_NONE);
      chkKinds('{IQR_K_RESLOAD, IQR_K_CONDSTORE, IQR_K_FENCE, IQR_K_READ, IQR_K_WRITE,
                 IQR_K_FENCE, IQR_K_WRITE});
      chkWord("header", 64'h0, i_iqr_mem_model.peek(64'h1000));
   endtask : longLast

   // Links below the header, upper read halves hold junk
   task automatic longSigned;
      i_iqr_mem_model.lag = 1;
      i_iqr_mem_model.wr(64'h2000, 64'hFFFF_FE00_FFFF_FF00, 1'b1);
      i_iqr_mem_model.wr(64'h1F00, 64'h0000_0100_FFFF_FF00, 1'b1);
      i_iqr_mem_model.wr(64'h1E00, 64'h0000_0100_0000_0200, 1'b1);
      run(64'h2000, 1'b0, 1'b0);
      chkResult(`IQR_ST_MORE, 64'h1F00, IQR_X_NONE);
      chkWord("back link addr", 64'h1E04, i_iqr_mem_model.addrs[4]);
      chkWord("header", 64'hFFFF_FE00_FFFF_FE00, i_iqr_mem_model.peek(64'h2000));
      chkWord("successor", 64'h0000_0200_0000_0200, i_iqr_mem_model.peek(64'h1E00));
   endtask : longSigned

   task automatic longEmptyRetry;
      i_iqr_mem_model.lag = 0;
      i_iqr_mem_model.wr(64'h5000, 64'h0, 1'b1);
      i_iqr_mem_model.scFails = 1;
      run(64'h5000, 1'b0, 1'b0);
      chkResult(`IQR_ST_EMPTY, 64'h5000, IQR_X_NONE);
      chkKinds('{IQR_K_RESLOAD, IQR_K_CONDSTORE, IQR_K_RESLOAD, IQR_K_CONDSTORE,
                 IQR_K_FENCE, IQR_K_WRITE, IQR_K_FENCE, IQR_K_WRITE});
      chkWord("header", 64'h0, i_iqr_mem_model.peek(64'h5000));
      i_iqr_mem_model.scFails = 2;
      run(64'h5000, 1'b0, 1'b0);
      chkWord("status", `IQR_ST_LOCKED, result.status);
      chkKinds('{IQR_K_RESLOAD, IQR_K_CONDSTORE, IQR_K_RESLOAD, IQR_K_CONDSTORE});
      chkWord("header", 64'h0, i_iqr_mem_model.peek(64'h5000));
   endtask : longEmptyRetry

   task automatic lockHeld;
      i_iqr_mem_model.wr(64'h4000, 64'h0000_0040_0000_0041, 1'b1);
      run(64'h4000, 1'b0, 1'b0);
      chkWord("status", `IQR_ST_LOCKED, result.status);
      chkKinds('{IQR_K_RESLOAD});
      chkWord("header", 64'h0000_0040_0000_0041, i_iqr_mem_model.peek(64'h4000));
   endtask : lockHeld

   // Faults after the lock do not stop the long variant
   task automatic longNoChecks;
      i_iqr_mem_model.faultAddr = 64'hA040;
      i_iqr_mem_model.faultCode = IQR_X_FOR;
      i_iqr_mem_model.wr(64'hA000, 64'h0000_0040_0000_0040, 1'b1);
      i_iqr_mem_model.wr(64'hA040, 64'hFFFF_FFC0_FFFF_FFC0, 1'b1);
      run(64'hA000, 1'b0, 1'b0);
      chkResult(`IQR_ST_NOW_EMPTY, 64'hA040, IQR_X_NONE);
      i_iqr_mem_model.faultCode = IQR_X_NONE;
   endtask : longNoChecks

   task automatic quadRemove;
      i_iqr_mem_model.wr(64'h7000, 64'h100, 1'b1);
      i_iqr_mem_model.wr(64'h7008, 64'h200, 1'b1);
      i_iqr_mem_model.wr(64'h7100, 64'h100, 1'b1);
      i_iqr_mem_model.wr(64'h7200, 64'hFFFF_FFFF_FFFF_FE00, 1'b1);
      i_iqr_mem_model.wr(64'h7208, 64'hFFFF_FFFF_FFFF_FF00, 1'b1);
      run(64'h7000, 1'b1, 1'b0);
      chkResult(`IQR_ST_MORE, 64'h7100, IQR_X_NONE);
      chkKinds('{IQR_K_RESLOAD, IQR_K_CONDSTORE, IQR_K_FENCE, IQR_K_READ, IQR_K_PROBEW,
                 IQR_K_WRITE, IQR_K_FENCE, IQR_K_WRITE});
      chkWord("header", 64'h200, i_iqr_mem_model.peek(64'h7000));
      chkWord("back link", 64'hFFFF_FFFF_FFFF_FE00, i_iqr_mem_model.peek(64'h7208));
   endtask : quadRemove

   task automatic quadMisaligned;
      run(64'h6008, 1'b1, 1'b0);
      chkExc("exception", IQR_X_ILLOP, result.exc);
      chkWord("transfer count", 64'h0, 64'(i_iqr_mem_model.kinds.size()));
      i_iqr_mem_model.wr(64'h8000, 64'h108, 1'b1);
      run(64'h8000, 1'b1, 1'b0);
      chkExc("exception", IQR_X_ILLOP, result.exc);
      chkWord("header", 64'h108, i_iqr_mem_model.peek(64'h8000));
      i_iqr_mem_model.wr(64'hC000, 64'h100, 1'b1);
      i_iqr_mem_model.wr(64'hC100, 64'h108, 1'b1);
      run(64'hC000, 1'b1, 1'b0);
      chkExc("exception", IQR_X_ILLOP, result.exc);
      chkWord("header", 64'h100, i_iqr_mem_model.peek(64'hC000));
   endtask : quadMisaligned

   // Empty quad queue, then a fault on the header read itself
   task automatic quadEmpty;
      i_iqr_mem_model.wr(64'hB000, 64'h0, 1'b1);
      run(64'hB000, 1'b1, 1'b0);
      chkResult(`IQR_ST_EMPTY, 64'hB000, IQR_X_NONE);
      chkKinds('{IQR_K_RESLOAD, IQR_K_CONDSTORE, IQR_K_FENCE, IQR_K_PROBEW, IQR_K_WRITE,
                 IQR_K_FENCE, IQR_K_WRITE});
      i_iqr_mem_model.faultAddr = 64'hB000;
      i_iqr_mem_model.faultCode = IQR_X_TNV;
      run(64'hB000, 1'b1, 1'b0);
      chkExc("exception", IQR_X_TNV, result.exc);
      chkWord("transfer count", 64'h1, 64'(i_iqr_mem_model.kinds.size()));
      i_iqr_mem_model.faultCode = IQR_X_NONE;
   endtask : quadEmpty

   task automatic quadFault;
      iqr_exc_t codes[4] = '{IQR_X_ACCVIO, IQR_X_FOR, IQR_X_FOW, IQR_X_TNV};
      i_iqr_mem_model.faultAddr = 64'h9008;
      foreach (codes[i])
      begin
         i_iqr_mem_model.faultCode = codes[i];
         i_iqr_mem_model.wr(64'h9000, 64'h100, 1'b1);
         i_iqr_mem_model.wr(64'h9008, 64'h100, 1'b1);
         i_iqr_mem_model.wr(64'h9100, 64'hFFFF_FFFF_FFFF_FF00, 1'b1);
         run(64'h9000, 1'b1, 1'b0);
         chkExc("exception", codes[i], result.exc);
         chkWord("header", 64'h100, i_iqr_mem_model.peek(64'h9000));
         chkWord("back link", 64'h100, i_iqr_mem_model.peek(64'h9008));
      end
      i_iqr_mem_model.faultCode = IQR_X_NONE;
   endtask : quadFault

   task automatic wrap_up;
      if (failures == 0 && checksDone > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // Reset, then every scenario back to back
   initial
   begin
      rst_b = 1'b0;
      start = '0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      longLast();
      longSigned();
      longEmptyRetry();
      lockHeld();
      longNoChecks();
      quadRemove();
      quadMisaligned();
      quadEmpty();
      quadFault();
      wrap_up();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need
   initial
   begin
      #200000;
      failures++;
      wrap_up();
   end
endmodule : interlocked_queue_head_remove_test
`default_nettype wire
